// >>> hw/uft_frame_timer.sv
`timescale 1ns/10ps
// Behaviour
// - Frame interval is a 14-bit field in bits 13..0, bit times per frame minus one.
// - Frame interval resets to 11999, so a frame is 12000 bit times.
// - Controller reset request restores nominal interval, dropping any written value.
// - Each frame start loads bits 30..16 into the largest-packet counter.
// - Largest-packet counter is the bit limit for one transaction now.
// - Interval writes are accepted at any time, including every frame start; a same-cycle reset request overrides bits 13..0.
// - Code 0Dh reads the interval register, 8Dh writes it.
// - 14-bit remaining-time down counter, read by 0Eh, written by 8Eh.
module uft_frame_timer
(
    input  wire logic            mclk_i,
    input  wire logic            reset_n_i,
    input  wire uft_pkg::uft_cmd_t cmd_i,
    input  wire logic            controller_reset_request_i,
    output uft_pkg::uft_rsp_t    rsp_o,
    output logic                 sof_o,
    output logic [13:0]          frame_time_remaining_o,
    output logic [14:0]          largest_packet_left_o
);
    import uft_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic        interval_toggle;
        logic [14:0] largest_packet_bits;
        logic [13:0] frame_interval;
        logic        remaining_toggle;
        logic [13:0] remaining;
        logic [14:0] lp_count;
        logic        sof;
        uft_rsp_t    rsp;
    } uft_state_t;

    uft_state_t st_ff;
    uft_state_t nxt_st;
    logic       bit_tick;

    uft_bit_tick u_bit_tick
    (
        .mclk_i     (mclk_i),
        .reset_n_i  (reset_n_i),
        .bit_tick_o (bit_tick)
    );

    // ****************************************
    // Helpers
    // ****************************************
    // Saturating step: counters park at zero instead of wrapping to all ones
    function automatic logic [14:0] sat_dec(input logic [14:0] v);
        sat_dec = (v == 15'h0000) ? 15'h0000 : v - 15'h0001;
    endfunction

    // Interval field of a command word
    function automatic logic [13:0] interval_of(input logic [31:0] w);
        interval_of = w[INTERVAL_LSB +: INTERVAL_W];
    endfunction

    // Toggle bit of a command word, shared by both write codes
    function automatic logic toggle_of(input logic [31:0] w);
        toggle_of = w[TOGGLE_BIT];
    endfunction

    // Largest-packet field of a command word
    function automatic logic [14:0] packet_of(input logic [31:0] w);
        packet_of = w[LPB_LSB +: LPB_W];
    endfunction

    // Read word of the interval register; reserved bits read as zero
    function automatic logic [31:0] interval_word(input logic        tgl,
                                                  input logic [14:0] pkt,
                                                  input logic [13:0] ivl);
        interval_word = {tgl, pkt, 2'b00, ivl};
    endfunction

    // Read word of the remaining register; reserved bits read as zero
    function automatic logic [31:0] remaining_word(input logic        tgl,
                                                   input logic [13:0] rem);
        remaining_word = {tgl, 17'h00000, rem};
    endfunction

    // True for one of the two read codes
    function automatic logic is_read(input logic [7:0] c);
        is_read = (c == CMD_RD_INTERVAL) || (c == CMD_RD_REMAINING);
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        nxt_st           = st_ff;
        nxt_st.sof       = 1'b0;
        nxt_st.rsp.valid = 1'b0;

        // Bit-time countdown and frame rollover
        if (bit_tick)
        begin
            if (st_ff.remaining == 14'h0000)
            begin
                nxt_st.remaining        = st_ff.frame_interval;
                nxt_st.remaining_toggle = st_ff.interval_toggle;
                nxt_st.lp_count         = st_ff.largest_packet_bits;
                nxt_st.sof              = 1'b1;
            end
            else
            begin
                nxt_st.remaining = 14'(sat_dec({1'b0, st_ff.remaining}));
                nxt_st.lp_count  = sat_dec(st_ff.lp_count);
            end
        end

        // Software commands; writes win over the countdown in the same cycle
        if (cmd_i.valid)
        begin
            case (cmd_i.code)
                CMD_WR_INTERVAL:
                begin
                    nxt_st.frame_interval      = interval_of(cmd_i.data);
                    nxt_st.largest_packet_bits = packet_of(cmd_i.data);
                    nxt_st.interval_toggle     = toggle_of(cmd_i.data);
                end
                CMD_WR_REMAINING:
                begin
                    nxt_st.remaining        = interval_of(cmd_i.data);
                    nxt_st.remaining_toggle = toggle_of(cmd_i.data);
                end
                CMD_RD_INTERVAL:
                begin
                    nxt_st.rsp.valid = is_read(cmd_i.code);
                    nxt_st.rsp.data  = interval_word(st_ff.interval_toggle,
                                                     st_ff.largest_packet_bits,
                                                     st_ff.frame_interval);
                end
                CMD_RD_REMAINING:
                begin
                    nxt_st.rsp.valid = is_read(cmd_i.code);
                    nxt_st.rsp.data  = remaining_word(st_ff.remaining_toggle,
                                                      st_ff.remaining);
                end
                default:
                begin
                    nxt_st.rsp.valid = 1'b0;
                end
            endcase
        end

        // Reset request outranks a same-cycle interval write
        if (controller_reset_request_i)
        begin
            nxt_st.frame_interval = INTERVAL_NOMINAL;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st_ff                     <= '0;
            st_ff.frame_interval      <= INTERVAL_NOMINAL;
            st_ff.largest_packet_bits <= LPB_RESET;
            st_ff.remaining           <= REMAINING_RESET;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rsp_o                  = st_ff.rsp;
    assign sof_o                  = st_ff.sof;
    assign frame_time_remaining_o = st_ff.remaining;
    assign largest_packet_left_o  = st_ff.lp_count;

endmodule

// >>> hw/uft_pkg.sv
package uft_pkg;

    // ****************************************
    // Command codes
    // ****************************************
    localparam logic [7:0]  CMD_RD_INTERVAL   = 8'h0D;
    localparam logic [7:0]  CMD_WR_INTERVAL   = 8'h8D;
    localparam logic [7:0]  CMD_RD_REMAINING  = 8'h0E;
    localparam logic [7:0]  CMD_WR_REMAINING  = 8'h8E;

    // ****************************************
    // Field layout
    // ****************************************
    localparam int          INTERVAL_LSB      = 0;
    localparam int          INTERVAL_W        = 14;
    localparam int          LPB_LSB           = 16;
    localparam int          LPB_W             = 15;
    localparam int          TOGGLE_BIT        = 31;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [13:0] INTERVAL_NOMINAL  = 14'h2EDF;
    localparam logic [14:0] LPB_RESET         = 15'h0000;
    localparam logic [13:0] REMAINING_RESET   = 14'h0000;

    // ****************************************
    // Bit-time rate
    // ****************************************
    localparam int          CLK_HZ            = 250_000_000;
    localparam int          BIT_HZ            = 12_000_000;
    localparam int          RATE_GCD          = 1_000_000;
    localparam logic [8:0]  ACC_STEP          = 9'(BIT_HZ / RATE_GCD);
    localparam logic [8:0]  ACC_MOD           = 9'(CLK_HZ / RATE_GCD);

    // ****************************************
    // Carriers
    // ****************************************
    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [31:0] data;
    } uft_cmd_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } uft_rsp_t;

endpackage

// >>> hw/uft_bit_tick.sv
`timescale 1ns/10ps
module uft_bit_tick
(
    input  wire logic mclk_i,
    input  wire logic reset_n_i,
    output logic      bit_tick_o
);
    import uft_pkg::*;

    typedef struct packed {
        logic [8:0] acc;
        logic       tick;
    } uft_tick_st_t;

    uft_tick_st_t st_ff;
    uft_tick_st_t nxt_st;
    logic [8:0]   sum;

    // Fractional accumulator: exact 12 MHz average, jitter of one clock
    always_comb
    begin
        nxt_st = st_ff;
        sum    = st_ff.acc + ACC_STEP;
        if (sum >= ACC_MOD)
        begin
            nxt_st.acc  = sum - ACC_MOD;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.acc  = sum;
            nxt_st.tick = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign bit_tick_o = st_ff.tick;

endmodule

// >>> dv/uft_mon_monitor.sv
`timescale 1ns/10ps
module uft_mon
(
    input wire logic              mclk_i,
    input wire logic              reset_n_i,
    input wire uft_pkg::uft_cmd_t cmd_i,
    input wire logic              controller_reset_request_i,
    input wire uft_pkg::uft_rsp_t rsp_o,
    input wire logic              sof_o,
    input wire logic [13:0]       frame_time_remaining_o,
    input wire logic [14:0]       largest_packet_left_o
);
    import uft_pkg::*;
    wire logic rd_int = cmd_i.valid && cmd_i.code == CMD_RD_INTERVAL;
    wire logic rd = rd_int || (cmd_i.valid && cmd_i.code == CMD_RD_REMAINING);
    wire logic wr_int = cmd_i.valid && cmd_i.code == CMD_WR_INTERVAL;
    wire logic wr_rem = cmd_i.valid && cmd_i.code == CMD_WR_REMAINING;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    property p_rd_ans; rd |=> rsp_o.valid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_no_spur; rsp_o.valid |-> $past(rd); endproperty
    a_no_spur: assert property (p_no_spur) else $error("answer without read");
    property p_int_rw; wr_int && !controller_reset_request_i ##1 !cmd_i.valid ##1 rd_int
        |=> rsp_o.data == ($past(cmd_i.data, 3) & 32'hFFFF3FFF); endproperty
    a_int_rw: assert property (p_int_rw) else $error("interval readback wrong");
    property p_int_rst; controller_reset_request_i ##1 !cmd_i.valid ##1 rd_int
        |=> rsp_o.data[13:0] == INTERVAL_NOMINAL; endproperty
    a_int_rst: assert property (p_int_rst) else $error("interval not nominal");
    property p_sof_zero; sof_o |-> $past(frame_time_remaining_o) == 14'h0000; endproperty
    a_sof_zero: assert property (p_sof_zero) else $error("frame start early");
    property p_sof_one; sof_o |=> !sof_o; endproperty
    a_sof_one: assert property (p_sof_one) else $error("frame start too long");
    property p_rem_step; !sof_o && !$past(wr_rem) && $changed(frame_time_remaining_o)
        |-> frame_time_remaining_o == $past(frame_time_remaining_o) - 14'h0001; endproperty
    a_rem_step: assert property (p_rem_step) else $error("remaining jumped");
    property p_rem_wr; wr_rem |=> frame_time_remaining_o == $past(cmd_i.data[13:0]); endproperty
    a_rem_wr: assert property (p_rem_wr) else $error("remaining not written");
    property p_lp_step; !sof_o && $changed(largest_packet_left_o)
        |-> largest_packet_left_o == $past(largest_packet_left_o) - 15'h0001; endproperty
    a_lp_step: assert property (p_lp_step) else $error("packet count jumped");
endmodule
bind uft_frame_timer uft_mon i_uft_mon (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_i(cmd_i),
    .controller_reset_request_i(controller_reset_request_i), .rsp_o(rsp_o), .sof_o(sof_o),
    .frame_time_remaining_o(frame_time_remaining_o), .largest_packet_left_o(largest_packet_left_o));

// >>> dv/uft_frame_timer_test.sv
`timescale 1ns/10ps
module uft_frame_timer_test;
    import uft_pkg::*;
    logic        mclk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        req = 1'b0;
    uft_cmd_t    cmd = '0;
    uft_rsp_t    rsp;
    logic        sof;
    logic [13:0] rem;
    logic [14:0] lpk;
    logic [31:0] d;
    logic [31:0] s;
    int          n_errors = 0;
    int          comparisons = 0;
    int          n;
    always #2 mclk_i = ~mclk_i;
    uft_frame_timer i_uft_frame_timer (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_i(cmd),
        .controller_reset_request_i(req), .rsp_o(rsp), .sof_o(sof),
        .frame_time_remaining_o(rem), .largest_packet_left_o(lpk));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] interval_word(input logic [31:0] v);
        return v & 32'hFFFF3FFF;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Read data is settled one step after the taking edge
    task automatic issue(input logic [7:0] c, input logic [31:0] v);
        @(posedge mclk_i);
        cmd <= '{1'b1, c, v};
        @(posedge mclk_i);
        cmd.valid <= 1'b0;
        #1;
    endtask
    task automatic wait_sof();
        n = 0;
        do
        begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (sof !== 1'b1 && n < 1000);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial
    begin
        void'($urandom(32'hDBAF0B04));
        repeat (16) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        issue(CMD_RD_INTERVAL, '0);
        chk("reset word", 32'h00002EDF, rsp.data);
        repeat (4)
        begin
            d = $urandom;
            issue(CMD_WR_INTERVAL, d);
            issue(CMD_RD_INTERVAL, '0);
            chk("interval word", interval_word(d), rsp.data);
        end
        $display("test register done");
        s = rsp.data;
        @(posedge mclk_i);
        req <= 1'b1;
        @(posedge mclk_i);
        req <= 1'b0;
        issue(CMD_RD_INTERVAL, '0);
        chk("after reset", (s & 32'hFFFFC000) | 32'h00002EDF, rsp.data);
        issue(CMD_WR_INTERVAL, s ^ 32'h80000000);
        issue(CMD_RD_INTERVAL, '0);
        chk("restored", s ^ 32'h80000000, rsp.data);
        $display("test controller reset done");
        issue(CMD_WR_INTERVAL, 32'h80050014);
        issue(CMD_WR_REMAINING, 32'h00000002);
        wait_sof();
        chk("reload remaining", 32'd20, {18'h0, rem});
        chk("packet load", 32'd5, {17'h0, lpk});
        issue(CMD_WR_INTERVAL, 32'h00030009);
        wait_sof();
        chk("long frame", 32'd1, {31'h0, n >= 430 && n <= 440});
        chk("new interval", 32'd9, {18'h0, rem});
        chk("new packet", 32'd3, {17'h0, lpk});
        wait_sof();
        chk("short frame", 32'd1, {31'h0, n >= 204 && n <= 212});
        issue(CMD_RD_REMAINING, '0);
        chk("remaining word", 32'h00000009, rsp.data);
        $display("test frame done");
        close_out();
    end
    initial
    begin
        #40000;
        n_errors++;
        close_out();
    end
endmodule
